/* sisq_cfg.svh */
`ifndef SISQ_CFG_SVH
`define SISQ_CFG_SVH

`define SISQ_OP_ASL_ACC_FIRST  8'h48
`define SISQ_OP_ASL_ACC_SECOND 8'h58
`define SISQ_OP_ASL_DOUBLE     8'h59
`define SISQ_OP_ASR_ACC_FIRST  8'h47
`define SISQ_OP_ASR_ACC_SECOND 8'h57
`define SISQ_OP_ASL_EXT        8'h78
`define SISQ_OP_ASL_IDX        8'h68
`define SISQ_OP_ASR_EXT        8'h77
`define SISQ_OP_ASR_IDX        8'h67
`define SISQ_BRANCH_ROW        4'h2

`define SISQ_MODE_IDX          3'h0
`define SISQ_MODE_IDX1         3'h1
`define SISQ_MODE_IDX2         3'h2
`define SISQ_MODE_D_IND        3'h3
`define SISQ_MODE_IDX2_IND     3'h4

`define SISQ_ACC_RESET         8'h00
`define SISQ_PAGE_RESET        8'h00
`define SISQ_WORD_RESET        16'h0000
`define SISQ_PC_STEP           16'h0002
`define SISQ_BYTE_HI           8'h00

`endif

/* sisq_pkg.sv */
package sisq_pkg;

	// One access code per bus cycle
	typedef enum logic [4:0] {
		AC_F, AC_G, AC_IPTR, AC_IPAGE, AC_N, AC_O, AC_P, AC_R8, AC_R16,
		AC_S8, AC_S16, AC_W8, AC_W16, AC_U8, AC_U16, AC_V, AC_T8, AC_T16, AC_X8
	} sisq_code_type;

	typedef enum logic [1:0] {BK_PROG, BK_DATA, BK_STACK, BK_VEC} sisq_kind_type;

	typedef enum logic [2:0] {
		OK_NONE, OK_ACC_FIRST, OK_ACC_SECOND, OK_DOUBLE, OK_MEM
	} sisq_op_type;

	typedef enum logic [2:0] {
		FC_KEEP, FC_CLEAR, FC_SET, FC_CALC, FC_CLR_ONLY, FC_SET_ONLY, FC_UNDEF, FC_SPECIAL
	} sisq_fclass_type;

	typedef struct packed {
		sisq_code_type [7:0] codes;
		logic [3:0]          len;
		logic [2:0]          loop_start;
		logic [2:0]          loop_end;
		logic [7:0]          irq_mask;
	} sisq_pattern_type;

	typedef struct packed {
		logic             busy;
		sisq_pattern_type pat;
		logic [2:0]       idx;
		logic [7:0]       loops_left;
		logic             opt_fetch;
		logic             dbl_pending;
		sisq_op_type      op;
		logic             shift_left;
		logic [15:0]      pc;
		logic [15:0]      ptr;
		logic             use_ptr;
		logic [7:0]       result;
		logic [15:0]      rdata;
		logic [7:0]       acc_first;
		logic [7:0]       acc_second;
		logic [7:0]       page;
		logic [7:0]       page_tmp;
		logic [3:0]       nzvc;
	} sisq_state_type;

endpackage : sisq_pkg

/* sisq_shifter.sv */
module sisq_shifter #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] value,
	input  wire logic             left,
	output logic      [WIDTH-1:0] result,
	output logic      [3:0]       nzvc
);
	logic carry;

	always_comb begin
		if (left) begin
			result = {value[WIDTH-2:0], 1'b0};
			carry  = value[WIDTH-1];
		end else begin
			result = {value[WIDTH-1], value[WIDTH-1:1]};
			carry  = value[0];
		end
		// Overflow is sign xor carry for both directions
		nzvc = {result[WIDTH-1], ~|result, result[WIDTH-1] ^ carry, carry};
	end

endmodule : sisq_shifter

/* sisq_sequencer.sv */
// Notes on behaviour
// - Every access code costs exactly one clock; markers cost none.
// - Uppercase codes are 16-bit transfers, lowercase codes 8-bit.
// - A free cycle leaves the bus idle.
// - Program fetch is always a 16-bit read at a word-aligned address.
// - Optional fetch becomes a program fetch only if misaligned and odd length.
// - A second-page prefix counts as its own one-byte instruction for alignment.
// - Vector fetch is a 16-bit word-aligned read.
// - Conditional reads either read or become free cycles.
// - Conditional byte write either writes or becomes a free cycle.
// - Pending interrupts are taken only at marked honour points.
// - Bracketed cycles repeat as a loop as often as required.
// - Short branch: three fetches if taken, one if not.
// - Long branch: optional, three fetches if taken; optional, fetch, optional if not.
// - Indirect pointer is read before the operand access that uses it.
// - Indirect page read fetches the new page value for indirect page calls.
// - Page read cycle reads the page register internally, no bus transfer.
// - Page write cycle writes the page register internally, no bus transfer.
// - Each status flag follows its class for the instruction.
// - Double-fetch instructions fetch the same program word twice.
// - Opcode 48 shifts first accumulator left, 58 the second.
// - Opcode 59 shifts the accumulator pair left, low byte into high, out to carry.
// - Double accumulator is first accumulator high byte, second low byte.
`include "sisq_cfg.svh"

module sisq_sequencer (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic                instr_valid,
	output logic                     instr_ready,
	input  wire logic [7:0]          instr_opcode,
	input  wire logic                instr_page2,
	input  wire logic [15:0]         instr_addr,
	input  wire logic [2:0]          instr_len,
	input  wire logic [2:0]          instr_idx_mode,
	input  wire logic                instr_dbl_fetch,
	input  wire logic                branch_taken,
	input  wire logic                use_ext_pattern,
	input  wire logic [39:0]         ext_codes,
	input  wire logic [3:0]          ext_len,
	input  wire logic [2:0]          ext_loop_start,
	input  wire logic [2:0]          ext_loop_end,
	input  wire logic [7:0]          ext_loop_count,
	input  wire logic [7:0]          ext_irq_mask,
	input  wire logic                cond_access,
	input  wire logic                irq_pending,
	output logic                     irq_take,
	input  wire logic [15:0]         operand_addr,
	input  wire logic [15:0]         sp_addr,
	input  wire logic [15:0]         vector_addr,
	input  wire logic [15:0]         stack_wdata,
	input  wire logic [15:0]         data_wdata,
	input  wire logic                acc_load_valid,
	input  wire logic [15:0]         acc_load_data,
	output logic                     bus_valid,
	output logic                     bus_write,
	output logic                     bus_wide,
	output sisq_pkg::sisq_kind_type  bus_kind,
	output logic [15:0]              bus_addr,
	output logic [15:0]              bus_wdata,
	input  wire logic [15:0]         bus_rdata,
	output logic [15:0]              read_data,
	output logic [7:0]               acc_first,
	output logic [7:0]               acc_second,
	output logic [7:0]               program_page_register,
	output logic [3:0]               flags_nzvc,
	output logic                     busy
);
	sisq_pkg::sisq_state_type s_reg;
	sisq_pkg::sisq_state_type s_next;
	sisq_pkg::sisq_code_type  eff;
	logic [7:0]               sh8_in;
	logic [7:0]               sh8_out;
	logic [3:0]               sh8_nzvc;
	logic [15:0]              sh16_out;
	logic [3:0]               sh16_nzvc;

	function automatic logic fclass(input sisq_pkg::sisq_fclass_type c, input logic old,
			input logic calc);
		case (c)
			sisq_pkg::FC_CLEAR:    fclass = 1'b0;
			sisq_pkg::FC_SET:      fclass = 1'b1;
			sisq_pkg::FC_CALC:     fclass = calc;
			sisq_pkg::FC_CLR_ONLY: fclass = old & calc;
			sisq_pkg::FC_SET_ONLY: fclass = old | calc;
			// Undefined and special flags keep their value here
			default:               fclass = old;
		endcase
	endfunction : fclass

	function automatic logic [3:0] apply_flags(input logic [3:0] old, input logic [3:0] calc);
		// Shifts compute N and Z from the result, C from the bit shifted out and V as N xor C
		for (int i = 0; i < 4; i++) begin
			apply_flags[i] = fclass(sisq_pkg::FC_CALC, old[i], calc[i]);
		end
	endfunction : apply_flags

	function automatic sisq_pkg::sisq_pattern_type build(input logic [7:0] op,
			input logic pg2, input logic [2:0] mode, input logic taken);
		sisq_pkg::sisq_pattern_type p;
		p = '0;
		p.codes = {8{sisq_pkg::AC_F}};
		p.len = 4'h1;
		if (op[7:4] == `SISQ_BRANCH_ROW) begin
			if (pg2 && taken) begin
				p.codes[3:0] = {sisq_pkg::AC_P, sisq_pkg::AC_P, sisq_pkg::AC_P, sisq_pkg::AC_O};
				p.len = 4'h4;
			end else if (pg2) begin
				p.codes[2:0] = {sisq_pkg::AC_O, sisq_pkg::AC_P, sisq_pkg::AC_O};
				p.len = 4'h3;
			end else if (taken) begin
				p.codes[2:0] = {3{sisq_pkg::AC_P}};
				p.len = 4'h3;
			end else begin
				p.codes[0] = sisq_pkg::AC_P;
			end
		end else if (op == `SISQ_OP_ASL_EXT || op == `SISQ_OP_ASR_EXT) begin
			p.codes[3:0] = {sisq_pkg::AC_O, sisq_pkg::AC_W8, sisq_pkg::AC_P, sisq_pkg::AC_R8};
			p.len = 4'h4;
		end else if (op == `SISQ_OP_ASL_IDX || op == `SISQ_OP_ASR_IDX) begin
			case (mode)
				`SISQ_MODE_IDX: begin
					p.codes[2:0] = {sisq_pkg::AC_W8, sisq_pkg::AC_P, sisq_pkg::AC_R8};
					p.len = 4'h3;
				end
				`SISQ_MODE_IDX1: begin
					p.codes[3:0] = {sisq_pkg::AC_O, sisq_pkg::AC_W8, sisq_pkg::AC_P,
						sisq_pkg::AC_R8};
					p.len = 4'h4;
				end
				`SISQ_MODE_IDX2: begin
					p.codes[4:0] = {sisq_pkg::AC_P, sisq_pkg::AC_W8, sisq_pkg::AC_P,
						sisq_pkg::AC_R8, sisq_pkg::AC_F};
					p.len = 4'h5;
				end
				`SISQ_MODE_D_IND: begin
					p.codes[5:0] = {sisq_pkg::AC_W8, sisq_pkg::AC_P, sisq_pkg::AC_R8,
						sisq_pkg::AC_F, sisq_pkg::AC_IPTR, sisq_pkg::AC_F};
					p.len = 4'h6;
				end
				default: begin
					p.codes[5:0] = {sisq_pkg::AC_W8, sisq_pkg::AC_P, sisq_pkg::AC_R8,
						sisq_pkg::AC_P, sisq_pkg::AC_IPTR, sisq_pkg::AC_F};
					p.len = 4'h6;
				end
			endcase
		end else begin
			// Inherent accumulator shifts and unknown opcodes: one optional fetch
			p.codes[0] = sisq_pkg::AC_O;
		end
		build = p;
	endfunction : build

	function automatic sisq_pkg::sisq_op_type classify(input logic [7:0] op);
		case (op)
			`SISQ_OP_ASL_ACC_FIRST, `SISQ_OP_ASR_ACC_FIRST:   classify = sisq_pkg::OK_ACC_FIRST;
			`SISQ_OP_ASL_ACC_SECOND, `SISQ_OP_ASR_ACC_SECOND: classify = sisq_pkg::OK_ACC_SECOND;
			`SISQ_OP_ASL_DOUBLE:                               classify = sisq_pkg::OK_DOUBLE;
			`SISQ_OP_ASL_EXT, `SISQ_OP_ASL_IDX,
			`SISQ_OP_ASR_EXT, `SISQ_OP_ASR_IDX:                classify = sisq_pkg::OK_MEM;
			default:                                           classify = sisq_pkg::OK_NONE;
		endcase
	endfunction : classify

	always_comb begin
		case (s_reg.op)
			sisq_pkg::OK_ACC_FIRST:  sh8_in = s_reg.acc_first;
			sisq_pkg::OK_ACC_SECOND: sh8_in = s_reg.acc_second;
			default:                 sh8_in = bus_rdata[7:0];
		endcase
	end

	sisq_shifter #(.WIDTH(8)) u_sh8 (
		.value  (sh8_in),
		.left   (s_reg.shift_left),
		.result (sh8_out),
		.nzvc   (sh8_nzvc)
	);

	sisq_shifter #(.WIDTH(16)) u_sh16 (
		.value  ({s_reg.acc_first, s_reg.acc_second}),
		.left   (1'b1),
		.result (sh16_out),
		.nzvc   (sh16_nzvc)
	);

	// Resolve optional and conditional codes to what the bus really sees
	always_comb begin
		eff = s_reg.pat.codes[s_reg.idx];
		case (eff)
			sisq_pkg::AC_O:  eff = s_reg.opt_fetch ? sisq_pkg::AC_P : sisq_pkg::AC_F;
			sisq_pkg::AC_T8, sisq_pkg::AC_T16: begin
				if (!cond_access) begin
					eff = sisq_pkg::AC_F;
				end
			end
			sisq_pkg::AC_X8: begin
				if (!cond_access) begin
					eff = sisq_pkg::AC_F;
				end
			end
			default: ;
		endcase
		if (!s_reg.busy) begin
			eff = sisq_pkg::AC_F;
		end
	end

	always_comb begin
		// Free cycles and internal page cycles stay off the bus
		bus_valid = !(eff inside {sisq_pkg::AC_F, sisq_pkg::AC_G, sisq_pkg::AC_N});
		bus_write = eff inside {sisq_pkg::AC_S8, sisq_pkg::AC_S16, sisq_pkg::AC_W8,
			sisq_pkg::AC_W16, sisq_pkg::AC_X8};
		bus_wide = eff inside {sisq_pkg::AC_P, sisq_pkg::AC_R16, sisq_pkg::AC_S16,
			sisq_pkg::AC_W16, sisq_pkg::AC_U16, sisq_pkg::AC_V, sisq_pkg::AC_T16,
			sisq_pkg::AC_IPTR};
		bus_wdata = s_reg.op == sisq_pkg::OK_MEM ? {`SISQ_BYTE_HI, s_reg.result} : data_wdata;
		case (eff)
			sisq_pkg::AC_P: begin
				bus_kind = sisq_pkg::BK_PROG;
				bus_addr = {s_reg.pc[15:1], 1'b0};
			end
			sisq_pkg::AC_V: begin
				bus_kind = sisq_pkg::BK_VEC;
				bus_addr = {vector_addr[15:1], 1'b0};
			end
			sisq_pkg::AC_S8, sisq_pkg::AC_S16, sisq_pkg::AC_U8, sisq_pkg::AC_U16: begin
				bus_kind = sisq_pkg::BK_STACK;
				bus_addr = sp_addr;
				bus_wdata = stack_wdata;
			end
			sisq_pkg::AC_IPTR: begin
				bus_kind = sisq_pkg::BK_DATA;
				bus_addr = operand_addr;
			end
			default: begin
				// Operand accesses follow the indirect pointer once it is read
				bus_kind = sisq_pkg::BK_DATA;
				bus_addr = s_reg.use_ptr ? s_reg.ptr : operand_addr;
			end
		endcase
	end

	always_comb begin
		logic [15:0] body_addr;
		logic [2:0]  body_len;
		body_addr = '0;
		body_len = '0;
		s_next = s_reg;
		irq_take = 1'b0;
		if (!s_reg.busy) begin
			if (acc_load_valid) begin
				{s_next.acc_first, s_next.acc_second} = acc_load_data;
			end
			if (instr_valid) begin
				// The prefix byte stands alone, so the body starts one byte later
				body_addr = instr_addr + {15'h0000, instr_page2};
				body_len = instr_len - {2'b00, instr_page2};
				s_next.busy = 1'b1;
				s_next.idx = '0;
				s_next.opt_fetch = body_addr[0] & body_len[0];
				s_next.dbl_pending = instr_dbl_fetch;
				s_next.pc = {body_addr[15:1], 1'b0};
				s_next.use_ptr = 1'b0;
				s_next.shift_left = instr_opcode[3];
				if (use_ext_pattern) begin
					// Each five-bit field is one code; a single cast would keep only code 0
					for (int k = 0; k < 8; k++) begin
						s_next.pat.codes[k] = sisq_pkg::sisq_code_type'(ext_codes[5*k +: 5]);
					end
					s_next.pat.len = ext_len;
					s_next.pat.loop_start = ext_loop_start;
					s_next.pat.loop_end = ext_loop_end;
					s_next.pat.irq_mask = ext_irq_mask;
					s_next.loops_left = ext_loop_count;
					s_next.op = sisq_pkg::OK_NONE;
				end else begin
					s_next.pat = build(instr_opcode, instr_page2, instr_idx_mode, branch_taken);
					s_next.loops_left = '0;
					s_next.op = instr_page2 ? sisq_pkg::OK_NONE : classify(instr_opcode);
				end
			end
		end else begin
			case (eff)
				sisq_pkg::AC_P: begin
					if (s_reg.dbl_pending) begin
						s_next.dbl_pending = 1'b0;
					end else begin
						s_next.pc = s_reg.pc + `SISQ_PC_STEP;
					end
				end
				sisq_pkg::AC_IPTR: begin
					s_next.ptr = bus_rdata;
					s_next.use_ptr = 1'b1;
				end
				sisq_pkg::AC_IPAGE: s_next.page_tmp = bus_rdata[7:0];
				sisq_pkg::AC_G:     s_next.page_tmp = s_reg.page;
				sisq_pkg::AC_N:     s_next.page = s_reg.page_tmp;
				sisq_pkg::AC_R8, sisq_pkg::AC_R16, sisq_pkg::AC_U8, sisq_pkg::AC_U16,
				sisq_pkg::AC_T8, sisq_pkg::AC_T16, sisq_pkg::AC_V: begin
					s_next.rdata = bus_wide ? bus_rdata : {`SISQ_BYTE_HI, bus_rdata[7:0]};
					if (s_reg.op == sisq_pkg::OK_MEM) begin
						s_next.result = sh8_out;
						s_next.nzvc = apply_flags(s_reg.nzvc, sh8_nzvc);
					end
				end
				default: ;
			endcase
			// Accumulator shifts complete on their single cycle
			if (s_reg.idx == 3'h0) begin
				case (s_reg.op)
					sisq_pkg::OK_ACC_FIRST: begin
						s_next.acc_first = sh8_out;
						s_next.nzvc = apply_flags(s_reg.nzvc, sh8_nzvc);
					end
					sisq_pkg::OK_ACC_SECOND: begin
						s_next.acc_second = sh8_out;
						s_next.nzvc = apply_flags(s_reg.nzvc, sh8_nzvc);
					end
					sisq_pkg::OK_DOUBLE: begin
						{s_next.acc_first, s_next.acc_second} = sh16_out;
						s_next.nzvc = apply_flags(s_reg.nzvc, sh16_nzvc);
					end
					default: ;
				endcase
			end
			// One code per clock, loops jump back, interrupts only at marks
			if (s_reg.idx == s_reg.pat.loop_end && s_reg.loops_left != 8'h00) begin
				s_next.idx = s_reg.pat.loop_start;
				s_next.loops_left = s_reg.loops_left - 8'h01;
			end else if ({1'b0, s_reg.idx} + 4'h1 >= s_reg.pat.len) begin
				s_next.busy = 1'b0;
			end else if (s_reg.pat.irq_mask[s_reg.idx] && irq_pending) begin
				s_next.busy = 1'b0;
				irq_take = 1'b1;
			end else begin
				s_next.idx = s_reg.idx + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
			s_reg.acc_first <= `SISQ_ACC_RESET;
			s_reg.acc_second <= `SISQ_ACC_RESET;
			s_reg.page <= `SISQ_PAGE_RESET;
			s_reg.pc <= `SISQ_WORD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign instr_ready = !s_reg.busy;
	assign busy = s_reg.busy;
	assign read_data = s_reg.rdata;
	assign acc_first = s_reg.acc_first;
	assign acc_second = s_reg.acc_second;
	assign program_page_register = s_reg.page;
	assign flags_nzvc = s_reg.nzvc;

endmodule : sisq_sequencer

/* sisq_seq_assertions.sv */
`include "sisq_cfg.svh"

module sisq_seq_assertions (
	input wire logic                    sys_clk,
	input wire logic                    rstn,
	input wire logic                    instr_valid,
	input wire logic                    instr_ready,
	input wire logic [7:0]              instr_opcode,
	input wire logic                    instr_page2,
	input wire logic                    branch_taken,
	input wire logic                    use_ext_pattern,
	input wire logic                    bus_valid,
	input wire logic                    bus_write,
	input wire logic                    bus_wide,
	input wire sisq_pkg::sisq_kind_type bus_kind,
	input wire logic [15:0]             bus_addr,
	input wire logic [7:0]              acc_first,
	input wire logic [7:0]              acc_second,
	input wire logic                    busy
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	logic go;
	logic br;
	assign go = instr_valid && instr_ready && !use_ext_pattern;
	assign br = go && instr_opcode[7:4] == `SISQ_BRANCH_ROW;

	sequence fetch_s;
		bus_valid && !bus_write && bus_kind == sisq_pkg::BK_PROG;
	endsequence
	sequence rd_s;
		bus_valid && !bus_write && !bus_wide && bus_kind == sisq_pkg::BK_DATA;
	endsequence
	sequence wr_s;
		bus_valid && bus_write && !bus_wide && bus_kind == sisq_pkg::BK_DATA;
	endsequence

	prog_fetch_a: assert property (fetch_s |-> bus_wide && !bus_addr[0])
		else $error("program fetch not an aligned word read");
	vec_fetch_a: assert property (bus_valid && bus_kind == sisq_pkg::BK_VEC
		|-> !bus_write && bus_wide && !bus_addr[0]) else $error("vector fetch malformed");
	idle_bus_a: assert property (!busy |-> !bus_valid)
		else $error("bus active while idle");
	accept_busy_a: assert property (instr_valid && instr_ready |=> busy && !instr_ready)
		else $error("accepted instruction did not start");
	shift_first_a: assert property (go && !instr_page2 && instr_opcode == 8'h48
		|=> ##1 !busy && acc_first == $past(acc_first, 2) << 1) else $error("first shift wrong");
	shift_second_a: assert property (go && !instr_page2 && instr_opcode == 8'h58
		|=> ##1 !busy && acc_second == $past(acc_second, 2) << 1) else $error("second shift wrong");
	shift_double_a: assert property (go && !instr_page2 && instr_opcode == 8'h59
		|=> ##1 {acc_first, acc_second} == {$past(acc_first, 2), $past(acc_second, 2)} << 1)
		else $error("double shift wrong");
	short_taken_a: assert property (br && !instr_page2 && branch_taken
		|=> fetch_s [*3] ##1 !busy) else $error("short taken branch pattern wrong");
	short_skip_a: assert property (br && !instr_page2 && !branch_taken
		|=> fetch_s ##1 !busy) else $error("short untaken branch pattern wrong");
	long_taken_a: assert property (br && instr_page2 && branch_taken
		|=> busy ##1 fetch_s [*3] ##1 !busy) else $error("long taken branch pattern wrong");
	mem_shift_a: assert property (go && !instr_page2 && instr_opcode == 8'h78
		|=> rd_s ##1 fetch_s ##1 wr_s ##0 bus_addr == $past(bus_addr, 2))
		else $error("memory shift sequence wrong");
endmodule : sisq_seq_assertions

bind sisq_sequencer sisq_seq_assertions sisq_seq_assertions_inst (.sys_clk, .rstn, .instr_valid,
	.instr_ready, .instr_opcode, .instr_page2, .branch_taken, .use_ext_pattern, .bus_valid,
	.bus_write, .bus_wide, .bus_kind, .bus_addr, .acc_first, .acc_second, .busy);

/* sisq_mem_model.sv */
module sisq_mem_model (
	input wire logic        sys_clk,
	input wire logic        bus_valid,
	input wire logic        bus_write,
	input wire logic [15:0] bus_addr,
	output logic     [15:0] bus_rdata
);
	// Outside reads the bus changes every cycle, so stale data never looks valid
	logic [15:0] junk_reg = 16'h5A5A;
	always_ff @(posedge sys_clk) begin
		junk_reg <= ~junk_reg + 16'h0001;
	end
	assign bus_rdata = (bus_valid && !bus_write) ? (bus_addr ^ 16'hA5C3) : junk_reg;
endmodule : sisq_mem_model

/* shift_instr_bus_cycle_sequencer_tb.sv */
module shift_instr_bus_cycle_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [15:0] acc, cyc, nbus, nirq, rd;
		logic [3:0]  flg;
		logic        chk_wr;
		logic [7:0]  wr, pg;
	} sisq_note_type;
	logic        sys_clk, rstn, instr_valid, instr_page2, instr_dbl_fetch, branch_taken;
	logic        use_ext_pattern, cond_access, irq_pending, acc_load_valid;
	logic        instr_ready, irq_take, bus_valid, bus_write, bus_wide, busy;
	logic [7:0]  instr_opcode, ext_loop_count, ext_irq_mask, acc_first, acc_second, t, wr;
	logic [7:0]  program_page_register;
	logic [2:0]  instr_len, instr_idx_mode, ext_loop_start, ext_loop_end;
	logic [3:0]  ext_len, flags_nzvc;
	logic [39:0] ext_codes;
	logic [15:0] instr_addr, operand_addr, sp_addr, vector_addr, stack_wdata, data_wdata;
	logic [15:0] acc_load_data, bus_rdata, bus_addr, bus_wdata, read_data, d, a, r;
	logic [15:0] cyc, nb, ni;
	sisq_pkg::sisq_kind_type bus_kind;
	sisq_note_type           notes[$];
	sisq_note_type           e, n;
	int                      error_cnt, num_checks;

	sisq_sequencer sisq_sequencer_inst (.sys_clk, .rstn, .instr_valid, .instr_ready,
		.instr_opcode, .instr_page2, .instr_addr, .instr_len, .instr_idx_mode,
		.instr_dbl_fetch, .branch_taken, .use_ext_pattern, .ext_codes, .ext_len,
		.ext_loop_start, .ext_loop_end, .ext_loop_count, .ext_irq_mask, .cond_access,
		.irq_pending, .irq_take, .operand_addr, .sp_addr, .vector_addr, .stack_wdata,
		.data_wdata, .acc_load_valid, .acc_load_data, .bus_valid, .bus_write, .bus_wide,
		.bus_kind, .bus_addr, .bus_wdata, .bus_rdata, .read_data, .acc_first, .acc_second,
		.program_page_register, .flags_nzvc, .busy);
	sisq_mem_model sisq_mem_model_inst (.sys_clk, .bus_valid, .bus_write, .bus_addr, .bus_rdata);

	always #5 sys_clk = ~sys_clk;

	function automatic logic [3:0] fl(input logic nf, input logic zf, input logic cf);
		return {nf, zf, nf ^ cf, cf};
	endfunction : fl

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic load(input logic [15:0] v);
		@(negedge sys_clk);
		acc_load_valid = 1'b1;
		acc_load_data = v;
		@(negedge sys_clk);
		acc_load_valid = 1'b0;
		e.acc = v;
	endtask : load

	task automatic issue(input logic [7:0] op, input logic pg2, input logic [2:0] len,
			input logic tk, input logic [15:0] c, input logic [15:0] nbv);
		int k;
		e.cyc = c;
		e.nbus = nbv;
		notes.push_back(e);
		@(negedge sys_clk);
		instr_opcode = op;
		instr_page2 = pg2;
		instr_len = len;
		instr_addr = a;
		branch_taken = tk;
		instr_valid = 1'b1;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		k = 0;
		while (busy !== 1'b0 && k < 60) begin
			@(negedge sys_clk);
			k++;
		end
		e.chk_wr = 1'b0;
		e.nirq = 16'h0000;
		if (k == 60) begin
			error_cnt++;
			report_and_stop();
		end
	endtask : issue

	// Counts what each instruction did on the bus and compares once it retires
	always @(negedge sys_clk) begin
		if (busy === 1'b1) begin
			cyc = cyc + 16'h0001;
			nb = nb + {15'h0000, bus_valid === 1'b1};
			ni = ni + {15'h0000, irq_take === 1'b1};
			if (bus_valid === 1'b1 && bus_write === 1'b1) wr = bus_wdata[7:0];
		end else if (cyc != 16'h0000 && notes.size() > 0) begin
			n = notes.pop_front();
			check("cycles", cyc, n.cyc);
			check("bus transfers", nb, n.nbus);
			check("irq taken", ni, n.nirq);
			check("accumulators", {acc_first, acc_second}, n.acc);
			check("flags", {12'h000, flags_nzvc}, {12'h000, n.flg});
			if (n.chk_wr) check("write data", {8'h00, wr}, {8'h00, n.wr});
			if (n.chk_wr) check("read data", read_data, n.rd);
			check("page", {8'h00, program_page_register}, {8'h00, n.pg});
			cyc = 16'h0000;
			nb = 16'h0000;
			ni = 16'h0000;
		end
	end

	initial begin
		{sys_clk, rstn, instr_valid, instr_page2, instr_dbl_fetch, branch_taken} = '0;
		{use_ext_pattern, cond_access, irq_pending, acc_load_valid, instr_opcode} = '0;
		{ext_loop_count, ext_irq_mask, instr_len, instr_idx_mode, ext_loop_start} = '0;
		{ext_loop_end, ext_len, ext_codes, instr_addr, operand_addr, sp_addr} = '0;
		{vector_addr, stack_wdata, data_wdata, acc_load_data, cyc, nb, ni, wr} = '0;
		e = '{default: '0};
		void'($urandom(17830));
		sp_addr = 16'($urandom);
		data_wdata = 16'($urandom);
		stack_wdata = 16'($urandom);
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		for (int i = 0; i < 9; i++) begin
			d = 16'($urandom);
			load(d);
			r = d << 1;
			case (i % 3)
				0: begin
					e.acc = {d[14:8], 1'b0, d[7:0]};
					e.flg = fl(d[14], d[14:8] == 7'h00, d[15]);
				end
				1: begin
					e.acc = {d[15:8], d[6:0], 1'b0};
					e.flg = fl(d[6], d[6:0] == 7'h00, d[7]);
				end
				default: begin
					e.acc = r;
					e.flg = fl(r[15], r == 16'h0000, d[15]);
				end
			endcase
			a = 16'($urandom);
			issue(i % 3 == 0 ? 8'h48 : i % 3 == 1 ? 8'h58 : 8'h59, 1'b0, 3'h1, 1'b0, 16'h0001,
				{15'h0000, a[0]});
			a = 16'($urandom);
			issue(8'h48, 1'b1, 3'h2, 1'b0, 16'h0001, {15'h0000, !a[0]});
		end
		instr_idx_mode = 3'h3;
		for (int i = 0; i < 6; i++) begin
			operand_addr = 16'($urandom);
			// Indirect forms read the pointer first, so the operand read returns the address
			d = i < 4 ? operand_addr ^ 16'hA5C3 : operand_addr;
			t = i[0] ? {d[6:0], 1'b0} : {d[7], d[7:1]};
			e.flg = fl(t[7], t == 8'h00, i[0] ? d[7] : d[0]);
			e.chk_wr = 1'b1;
			e.wr = t;
			e.rd = {8'h00, d[7:0]};
			a = 16'($urandom);
			if (i < 4) issue(i[0] ? 8'h78 : 8'h77, 1'b0, 3'h3, 1'b0, 16'h0004,
				16'h0003 + {15'h0000, a[0]});
			else issue(i[0] ? 8'h68 : 8'h67, 1'b0, 3'h2, 1'b0, 16'h0006, 16'h0004);
		end
		for (int i = 0; i < 8; i++) begin
			a = 16'($urandom);
			if (i < 4) issue({4'h2, 4'($urandom)}, 1'b0, 3'h2, i[0], i[0] ? 16'h0003 : 16'h0001,
				i[0] ? 16'h0003 : 16'h0001);
			else issue({4'h2, 4'($urandom)}, 1'b1, 3'h4, i[0], i[0] ? 16'h0004 : 16'h0003,
				i[0] ? 16'h0003 + {15'h0000, !a[0]} : 16'h0001 + {14'h0000, !a[0], 1'b0});
		end
		ext_codes = {15'h0000, sisq_pkg::AC_N, sisq_pkg::AC_X8, sisq_pkg::AC_T8,
			sisq_pkg::AC_IPAGE, sisq_pkg::AC_V};
		e.pg = operand_addr[7:0] ^ 8'hC3;
		ext_len = 4'h5;
		ext_loop_start = 3'h2;
		ext_loop_end = 3'h2;
		ext_loop_count = 8'h02;
		use_ext_pattern = 1'b1;
		for (int i = 0; i < 4; i++) begin
			cond_access = i[0];
			irq_pending = i[1];
			ext_irq_mask = {7'h00, i[1]};
			vector_addr = 16'($urandom);
			e.nirq = {15'h0000, i[1]};
			issue(8'h00, 1'b0, 3'h1, 1'b0, i[1] ? 16'h0001 : 16'h0007,
				i[1] ? 16'h0001 : 16'h0002 + {13'h0000, i[0], 2'h0});
		end
		use_ext_pattern = 1'b0;
		repeat (4) @(negedge sys_clk);
		report_and_stop();
	end
endmodule : shift_instr_bus_cycle_sequencer_tb
